/* File: fepd_pkg.sv */
package fepd_pkg;
	// opcodes
	localparam logic [7:0] OP_WLATCH  = 8'h06;
	localparam logic [7:0] OP_SECTOR  = 8'h20;
	localparam logic [7:0] OP_BLK32   = 8'h52;
	localparam logic [7:0] OP_BLK64   = 8'hD8;
	localparam logic [7:0] OP_CHIP_A  = 8'h60;
	localparam logic [7:0] OP_CHIP_B  = 8'hC7;
	localparam logic [7:0] OP_PDOWN   = 8'hB9;
	localparam logic [7:0] OP_WAKE    = 8'hAB;
	// bit counts inside a frame
	localparam logic [5:0] BITS_OP    = 6'h08;
	localparam logic [5:0] BITS_ADDR  = 6'h20;
	// address field layout
	localparam int SECT_LSB  = 12;
	localparam int BLK32_LSB = 15;
	localparam int BLK64_LSB = 16;
	localparam int PROT_W    = 5;
	// timing at 20 MHz
	localparam int CLK_NS     = 50;
	localparam int T_SE_US    = 100;
	localparam int T_CE_US    = 1000;
	localparam int T_DP_NS    = 3000;
	localparam int T_RES_NS   = 20000;
	localparam int SE_CYC  = T_SE_US * 1000 / CLK_NS;
	localparam int CE_CYC  = T_CE_US * 1000 / CLK_NS;
	localparam int DP_CYC  = (T_DP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RES_CYC = (T_RES_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] ID_RESET = 8'h00;
endpackage : fepd_pkg

/* File: fepd_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module fepd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s1_q <= '0;
			q_o  <= '0;
		end
		else
		begin
			s1_q <= d_i;
			q_o  <= s1_q;
		end
	end
endmodule : fepd_sync

/* File: fepd_core.sv */
`timescale 1ns/1ps
module fepd_core #(
	parameter int SE_CYCLES  = fepd_pkg::SE_CYC,
	parameter int CE_CYCLES  = fepd_pkg::CE_CYC,
	parameter int RES_CYCLES = fepd_pkg::RES_CYC,
	parameter logic [7:0] DEVICE_ID = fepd_pkg::ID_RESET // arbitrary value
) (
	input  wire logic                        CLK_SYS_I,
	input  wire logic                        RSTN_I,
	input  wire logic                        CS_N_I,
	input  wire logic                        SCLK_I,
	input  wire logic                        SI_I,
	input  wire logic [fepd_pkg::PROT_W-1:0] PROTECT_FIELD_I,
	input  wire logic [4:0]                  PROT_BLOCKS_I,
	output logic                             SO_O,
	output logic                             SO_OE_O,
	output logic                             CYCLE_IN_PROGRESS_O,
	output logic                             WRITE_LATCH_O,
	output logic                             POWER_DOWN_O,
	output logic                             ERASE_STB_O,
	output logic [1:0]                       ERASE_KIND_O,
	output logic [23:0]                      ERASE_ADDR_O
);
	typedef enum logic [1:0] {
		FEPD_IDLE = 2'b00,
		FEPD_BUSY = 2'b01,
		FEPD_PDWN = 2'b10,
		FEPD_WAKE = 2'b11
	} fepd_mode_t;

	typedef struct packed {
		fepd_mode_t  mode;
		logic [31:0] cnt;
		logic [5:0]  bits;
		logic [7:0]  op;
		logic [23:0] addr;
		logic [2:0]  id_bit;
		logic        wlatch;
		logic        pd_pend;
		logic        so;
		logic        so_oe;
		logic        stb;
		logic [1:0]  kind;
		logic [23:0] eaddr;
		logic        cs_n;
		logic        sclk;
		logic        busy;
		logic        pdwn;
	} fepd_state_t;

	fepd_state_t s_q, s_d;
	logic [2:0]  pin_sync;
	logic        cs_n, sclk, si;
	logic        rise_clk, fall_clk, cs_rise, cs_fall;

	// pins pass two flops before use; select goes in inverted so the
	// synchroniser's zero reset reads as deselected, no false frame
	fepd_sync #(.W(3)) u_sync (
		.clk_i  (CLK_SYS_I),
		.rstn_i (RSTN_I),
		.d_i    ({~CS_N_I, SCLK_I, SI_I}),
		.q_o    (pin_sync)
	);
	assign cs_n = ~pin_sync[2];
	assign sclk = pin_sync[1];
	assign si   = pin_sync[0];

	// edge detect on synchronised copies
	assign rise_clk = sclk & ~s_q.sclk & ~cs_n;
	assign fall_clk = ~sclk & s_q.sclk & ~cs_n;
	assign cs_rise  = cs_n & ~s_q.cs_n;
	assign cs_fall  = ~cs_n & s_q.cs_n;

	// region protected: upper 64KB blocks counted from top
	function automatic logic prot_hit(input logic [23:0] a,
		input logic [4:0] n);
		logic [5:0] top;
		top = 6'h3F - {1'b0, n};
		prot_hit = (n != 5'h00) && ({1'b0, a[21:16]} > top);
	endfunction : prot_hit

	always_comb
	begin
		s_d      = s_q;
		s_d.cs_n = cs_n;
		s_d.sclk = sclk;
		s_d.stb  = 1'b0;
		// frame start resets shifter
		if (cs_fall)
		begin
			s_d.bits   = '0;
			s_d.id_bit = '0;
		end
		// sample on rising clock, msb first
		if (rise_clk && s_q.bits != 6'h3F)
		begin
			if (s_q.bits < fepd_pkg::BITS_OP)
				s_d.op = {s_q.op[6:0], si};
			else
				s_d.addr = {s_q.addr[22:0], si};
			s_d.bits = s_q.bits + 6'h01;
		end
		// identity out on falling clock after dummies
		if (fall_clk && s_q.op == fepd_pkg::OP_WAKE
			&& s_q.bits >= fepd_pkg::BITS_ADDR
			&& s_q.mode == FEPD_IDLE)
		begin
			s_d.so     = DEVICE_ID[3'h7 - s_q.id_bit];
			s_d.so_oe  = 1'b1;
			s_d.id_bit = s_q.id_bit + 3'h1; // wraps: repeats
		end
		if (cs_n)
			s_d.so_oe = 1'b0; // select high ends read
		// command decode at select rise
		if (cs_rise)
		begin
			unique case (s_q.mode)
				FEPD_IDLE:
				begin
					if (s_q.bits == fepd_pkg::BITS_OP)
					begin
						if (s_q.op == fepd_pkg::OP_WLATCH)
							s_d.wlatch = 1'b1;
						else if ((s_q.op == fepd_pkg::OP_CHIP_A
							|| s_q.op == fepd_pkg::OP_CHIP_B)
							&& s_q.wlatch
							&& PROTECT_FIELD_I == '0)
						begin
							s_d.mode  = FEPD_BUSY;
							s_d.cnt   = 32'(CE_CYCLES);
							s_d.stb   = 1'b1;
							s_d.kind  = 2'b11;
							s_d.eaddr = '0;
						end
						else if (s_q.op == fepd_pkg::OP_PDOWN)
						begin
							s_d.mode    = FEPD_BUSY; // wait delay
							s_d.pd_pend = 1'b1;
							s_d.cnt     = 32'(fepd_pkg::DP_CYC);
						end
					end
					else if (s_q.bits == fepd_pkg::BITS_ADDR
						&& s_q.wlatch
						&& !prot_hit(s_q.addr, PROT_BLOCKS_I))
					begin
						s_d.stb  = 1'b1;
						s_d.mode = FEPD_BUSY;
						s_d.cnt  = 32'(SE_CYCLES);
						if (s_q.op == fepd_pkg::OP_SECTOR)
						begin
							s_d.kind  = 2'b00;
							s_d.eaddr = {s_q.addr[23:fepd_pkg::SECT_LSB],
								12'h000};
						end
						else if (s_q.op == fepd_pkg::OP_BLK32)
						begin
							s_d.kind  = 2'b01;
							s_d.eaddr = {s_q.addr[23:fepd_pkg::BLK32_LSB],
								15'h0000};
						end
						else if (s_q.op == fepd_pkg::OP_BLK64)
						begin
							s_d.kind  = 2'b10;
							s_d.eaddr = {s_q.addr[23:fepd_pkg::BLK64_LSB],
								16'h0000};
						end
						else
						begin
							s_d.stb  = 1'b0; // not an erase
							s_d.mode = FEPD_IDLE;
						end
					end
				end
				// busy: power-down and wake refused
				FEPD_BUSY: ;
				FEPD_PDWN:
				begin
					if (s_q.bits >= fepd_pkg::BITS_OP
						&& s_q.op == fepd_pkg::OP_WAKE)
					begin
						s_d.mode = FEPD_WAKE;
						s_d.cnt  = 32'(RES_CYCLES);
					end
				end
				FEPD_WAKE: ; // nothing taken until released
			endcase
		end
		// self-timed cycle countdown
		if (s_q.mode == FEPD_BUSY || s_q.mode == FEPD_WAKE)
		begin
			if (s_q.cnt <= 32'd1)
			begin
				// standby after an erase or wake, power-down after the delay
				s_d.mode = s_q.pd_pend ? FEPD_PDWN : FEPD_IDLE;
				s_d.pd_pend = 1'b0;
				s_d.cnt = '0;
				if (!s_q.pd_pend && s_q.mode == FEPD_BUSY)
					s_d.wlatch = 1'b0; // cleared at cycle end
			end
			else
				s_d.cnt = s_q.cnt - 32'd1;
		end
		// flags decoded ahead so the ports come straight from flops
		// power-down delay is not an erase, so busy stays low
		s_d.busy = (s_d.mode == FEPD_BUSY) && !s_d.pd_pend;
		s_d.pdwn = (s_d.mode == FEPD_PDWN);
	end

	// all state in one register; reset lands in standby
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			s_q      <= '0;
			s_q.cs_n <= 1'b1;
			s_q.mode <= FEPD_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign SO_O    = s_q.so;
	assign SO_OE_O = s_q.so_oe;
	// busy flag covers erase cycles only
	assign CYCLE_IN_PROGRESS_O = s_q.busy;
	assign WRITE_LATCH_O       = s_q.wlatch;
	assign POWER_DOWN_O        = s_q.pdwn;
	assign ERASE_STB_O         = s_q.stb;
	assign ERASE_KIND_O        = s_q.kind;
	assign ERASE_ADDR_O        = s_q.eaddr;
endmodule : fepd_core

/* File: fepd_core_assertions.sv */
`timescale 1ns/1ps
// watches erase, latch and power-down outputs
module fepd_core_assertions #(
	parameter int SE_CYCLES = 2000,
	parameter int CE_CYCLES = 20000
) (
	input wire logic       CLK_SYS_I,
	input wire logic       RSTN_I,
	input wire logic       CS_N_I,
	input wire logic       SO_OE_O,
	input wire logic       CYCLE_IN_PROGRESS_O,
	input wire logic       WRITE_LATCH_O,
	input wire logic       POWER_DOWN_O,
	input wire logic       ERASE_STB_O,
	input wire logic [1:0] ERASE_KIND_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
	int busy_len_q;
	// length of the busy run, judged when it ends
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
		if (!RSTN_I)
			busy_len_q <= 0;
		else
			busy_len_q <= CYCLE_IN_PROGRESS_O ? busy_len_q + 1 : 0;
	property p_stb_busy; ERASE_STB_O |-> CYCLE_IN_PROGRESS_O; endproperty
	a_stb_busy: assert property (p_stb_busy) else $error("no busy");
	property p_stb_one; ERASE_STB_O |=> !ERASE_STB_O; endproperty
	a_stb_one: assert property (p_stb_one) else $error("long strobe");
	property p_latch; ERASE_STB_O |-> $past(WRITE_LATCH_O); endproperty
	a_latch: assert property (p_latch) else $error("no latch");
	property p_rise; $rose(CYCLE_IN_PROGRESS_O) |-> ERASE_STB_O; endproperty
	a_rise: assert property (p_rise) else $error("stray busy");
	property p_clr; $fell(CYCLE_IN_PROGRESS_O) |-> !WRITE_LATCH_O; endproperty
	a_clr: assert property (p_clr) else $error("latch kept");
	property p_len;
		$fell(CYCLE_IN_PROGRESS_O) |-> busy_len_q ==
			(ERASE_KIND_O == 2'h3 ? CE_CYCLES : SE_CYCLES);
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_pd; POWER_DOWN_O |-> !ERASE_STB_O; endproperty
	a_pd: assert property (p_pd) else $error("erase in sleep");
	property p_oe; $rose(CS_N_I) |-> ##6 !SO_OE_O; endproperty
	a_oe: assert property (p_oe) else $error("output kept");
endmodule : fepd_core_assertions
bind fepd_core fepd_core_assertions #(.SE_CYCLES(SE_CYCLES),
	.CE_CYCLES(CE_CYCLES)) fepd_core_assertions_inst (
	.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .CS_N_I(CS_N_I),
	.SO_OE_O(SO_OE_O), .CYCLE_IN_PROGRESS_O(CYCLE_IN_PROGRESS_O),
	.WRITE_LATCH_O(WRITE_LATCH_O), .POWER_DOWN_O(POWER_DOWN_O),
	.ERASE_STB_O(ERASE_STB_O), .ERASE_KIND_O(ERASE_KIND_O));

/* File: fepd_host.sv */
`timescale 1ns/1ps
// host: serial clock idles low, data toggles when released
module fepd_host (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o = 1'b1,
	output logic      sclk_o = 1'b0,
	output logic      si_o = 1'b0
);
	// n bits of d msb first, then r read clocks into q
	task automatic frame(input logic [31:0] d, input int n, input int r,
		output logic [15:0] q);
		q = 16'h0000;
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (int i = 0; i < n + r; i++)
		begin
			si_o <= i < n ? d[n - 1 - i] : ~si_o;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			if (i >= n)
				q = {q[14:0], so_i};
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
	endtask : frame
endmodule : fepd_host

/* File: flash_erase_and_power_down_test.sv */
`timescale 1ns/1ps
module flash_erase_and_power_down_test;
	localparam logic [7:0] ID = 8'h5A; // arbitrary value
	logic CLK_SYS_I = 1'b0;
	logic RSTN_I = 1'b0;
	logic [4:0] prot = 5'h00;
	logic [4:0] pblk = 5'h00;
	logic cs_n, sclk, si, so, oe, busy, wl, pd, stb;
	logic [1:0] kind;
	logic [23:0] addr;
	logic [15:0] q;
	int errors = 0;
	int compares = 0;
	int stbs = 0;
	always #25 CLK_SYS_I = ~CLK_SYS_I;
	// count erase starts
	always @(posedge CLK_SYS_I) if (stb) stbs++;
	fepd_core #(.SE_CYCLES(400), .CE_CYCLES(800), .RES_CYCLES(20),
		.DEVICE_ID(ID)) fepd_core_inst (.CLK_SYS_I(CLK_SYS_I),
		.RSTN_I(RSTN_I), .CS_N_I(cs_n), .SCLK_I(sclk), .SI_I(si),
		.PROTECT_FIELD_I(prot), .PROT_BLOCKS_I(pblk), .SO_O(so),
		.SO_OE_O(oe), .CYCLE_IN_PROGRESS_O(busy), .WRITE_LATCH_O(wl),
		.POWER_DOWN_O(pd), .ERASE_STB_O(stb), .ERASE_KIND_O(kind),
		.ERASE_ADDR_O(addr));
	fepd_host fepd_host_inst (.clk_i(CLK_SYS_I), .so_i(so), .cs_n_o(cs_n),
		.sclk_o(sclk), .si_o(si));
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// frame, then time for the select rise to be decoded
	task automatic cmd(input logic [31:0] d, input int n);
		fepd_host_inst.frame(d, n, 0, q);
		repeat (6) @(posedge CLK_SYS_I);
		#1; // look after the edge's updates have settled
	endtask : cmd
	task automatic idle(input int n);
		for (int k = 0; k < n && busy !== 1'b0; k++)
		begin
			@(posedge CLK_SYS_I);
			#1;
		end
		chk(busy, 0);
		if (busy !== 1'b0)
			stop_test();
	endtask : idle
	task automatic t_erase;
		logic [7:0] op [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
		logic [23:0] base [3] = '{24'h12B000, 24'h128000, 24'h120000};
		int s;
		for (int i = 0; i < 5; i++)
		begin
			s = stbs;
			cmd(32'h06, 8);
			chk(wl, 1);
			cmd(i < 3 ? {op[i], 24'h12B456} : op[i], i < 3 ? 32 : 8);
			chk(stbs - s, 1);
			chk(kind, i < 3 ? i : 3);
			if (i < 3)
				chk(addr, base[i]);
			chk(busy, 1);
			idle(900);
			chk(wl, 0);
		end
		$display("erase kinds done");
	endtask : t_erase
	task automatic t_refuse;
		int s;
		s = stbs;
		cmd({8'h20, 24'h0}, 32);
		cmd(32'h06, 8);
		cmd({8'h20, 24'h0}, 31);
		prot <= 5'h04;
		cmd(32'h60, 8);
		prot <= 5'h00;
		@(posedge CLK_SYS_I);
		pblk <= 5'h01;
		cmd({8'h20, 24'h3F0000}, 32);
		@(posedge CLK_SYS_I);
		pblk <= 5'h00;
		chk(stbs - s, 0);
		$display("refusals done");
	endtask : t_refuse
	task automatic t_pd;
		cmd({8'h20, 24'h0}, 32);
		cmd(32'hB9, 8);
		idle(900);
		repeat (70) @(posedge CLK_SYS_I);
		#1;
		chk(pd, 0);
		cmd(32'hB9, 8);
		repeat (fepd_pkg::DP_CYC) @(posedge CLK_SYS_I);
		#1;
		chk(pd, 1);
		cmd(32'h06, 8);
		chk(wl, 0);
		cmd(32'hAB, 8);
		repeat (24) @(posedge CLK_SYS_I);
		#1;
		chk(pd, 0);
		fepd_host_inst.frame(32'hAB000000, 32, 16, q);
		chk(q, {ID, ID});
		repeat (8) @(posedge CLK_SYS_I);
		#1;
		chk(oe, 0);
		$display("power-down done");
	endtask : t_pd
	initial
	begin
		repeat (8) @(posedge CLK_SYS_I);
		RSTN_I <= 1'b1;
		repeat (4) @(posedge CLK_SYS_I);
		t_erase();
		t_refuse();
		t_pd();
		stop_test();
	end
endmodule : flash_erase_and_power_down_test
